// ---- arc_top.sv ----
// Purpose: Result registers, threshold comparator, result counter and
//          overrange detector of a dual sigma-delta converter back end
// Assumes: Conversion results arrive as one-cycle valid pulses on core_clk
// Notes:   APB slave, one wait state on every access
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module arc_top
#(
  parameter int OVR_CYC = arc_pkg::OVR_CYC_DEF,
  parameter int CNT_W   = arc_pkg::CNT_W_DEF
)
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire arc_pkg::arc_res_t  cur_res,
  input  wire arc_pkg::arc_res_t  volt_res,
  input  wire arc_pkg::arc_res_t  temp_res,
  input  wire logic               ovr_raw,
  output var  logic [7:0]         conv_mode,
  output var  logic               irq
);
  import arc_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]       cfg_r;
  logic [7:0]       mode_r;
  logic [RES_W-1:0] thr_r;
  logic [CNT_W-1:0] tcl_r;
  logic [CNT_W-1:0] thv_r;
  logic [CNT_W-1:0] thv_nxt;
  logic [CNT_W-1:0] rcl_r;
  logic [CNT_W-1:0] rcv_r;
  logic [CNT_W-1:0] rcv_nxt;
  logic [RES_W-1:0] cur_r;
  logic [RES_W-1:0] volt_r;
  logic [RES_W-1:0] temp_r;
  logic [RES_W-1:0] vsh_r;
  logic [RES_W-1:0] tsh_r;
  logic             vsh_v_r;
  logic             tsh_v_r;
  logic [ST_W-1:0]  stat_r;
  logic [ST_W-1:0]  stat_nxt;
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] ist_nxt;
  logic [IRQ_W-1:0] imsk_r;
  logic [OVR_W-1:0] ovc_r;
  logic [OVR_W-1:0] ovc_nxt;
  logic             pready_r;
  logic             pslverr_r;
  logic [31:0]      prdata_r;
  logic             irq_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc_first = psel & penable & ~pready_r;
  wire fire      = psel & penable & pready_r;
  wire wr        = fire & pwrite;
  wire rd        = fire & ~pwrite;

  wire hit_cur  = (paddr == ADDR_CUR);
  wire hit_volt = (paddr == ADDR_VOLT);
  wire hit_temp = (paddr == ADDR_TEMP);
  wire hit_cfg  = (paddr == ADDR_CFG);
  wire hit_stat = (paddr == ADDR_STAT);
  wire hit_thr  = (paddr == ADDR_THR);
  wire hit_tcl  = (paddr == ADDR_TCL);
  wire hit_thv  = (paddr == ADDR_THV);
  wire hit_rcl  = (paddr == ADDR_RCL);
  wire hit_rcv  = (paddr == ADDR_RCV);
  wire hit_mode = (paddr == ADDR_MODE);
  wire hit_imsk = (paddr == ADDR_IMSK);
  wire hit_ist  = (paddr == ADDR_IST);

  wire mapped = hit_cur | hit_volt | hit_temp | hit_cfg | hit_stat
              | hit_thr | hit_tcl | hit_thv | hit_rcl | hit_rcv
              | hit_mode | hit_imsk | hit_ist;

  // Narrow registers sit in the low bits, upper bits read zero
  wire [31:0] rd_mux =
      hit_cur  ? 32'(cur_r)  :
      hit_volt ? 32'(volt_r) :
      hit_temp ? 32'(temp_r) :
      hit_cfg  ? 32'(cfg_r)  :
      hit_stat ? 32'(stat_r) :
      hit_thr  ? 32'(thr_r)  :
      hit_tcl  ? 32'(tcl_r)  :
      hit_thv  ? 32'(thv_r)  :
      hit_rcl  ? 32'(rcl_r)  :
      hit_rcv  ? 32'(rcv_r)  :
      hit_mode ? 32'(mode_r) :
      hit_imsk ? 32'(imsk_r) :
      hit_ist  ? 32'(ist_r)  : 32'h0000_0000;

  // Reserved config bit 1 is never stored, so it reads zero
  wire [7:0] cfg_wdata = pwdata[7:0] & CFG_WMSK;

  // ----------------------------------------------------------------
  // Threshold comparator
  // ----------------------------------------------------------------
  arc_cmp_mode_t cmp_mode;
  assign cmp_mode = arc_cmp_mode_t'(cfg_r[CFG_CMP_HI:CFG_CMP_LO]);

  wire              cur_ev   = cur_res.valid;
  wire [RES_W-1:0]  cur_neg  = RES_W'(-cur_res.data);
  wire [RES_W-1:0]  cur_abs  = cur_res.data[RES_W-1] ? cur_neg : cur_res.data;
  wire              at_thr   = (cur_abs >= thr_r);
  wire              counting = (cmp_mode == CMP_CNT_RST) | (cmp_mode == CMP_CNT_DEC);
  wire [CNT_W-1:0]  thv_inc  = thv_r + CNT_W'(1);
  wire [CNT_W-1:0]  thv_dec  = thv_r - CNT_W'(1);
  wire              thv_zero = (thv_r == '0);
  wire              thv_hit  = (thv_inc >= tcl_r);

  wire cmp_each = (cmp_mode == CMP_EACH) & at_thr;
  wire cmp_cnt  = counting & at_thr & thv_hit;
  wire cmp_ev   = cur_ev & (cmp_each | cmp_cnt);

  always_comb
  begin
    thv_nxt = thv_r;
    if (!counting)
    begin
      thv_nxt = '0;
    end
    else if (cur_ev && at_thr)
    begin
      thv_nxt = thv_hit ? '0 : thv_inc;
    end
    else if (cur_ev && cmp_mode == CMP_CNT_RST)
    begin
      thv_nxt = '0;
    end
    else if (cur_ev && !thv_zero)
    begin
      thv_nxt = thv_dec;
    end
  end

  // ----------------------------------------------------------------
  // Result counter
  // ----------------------------------------------------------------
  wire             rcm     = cfg_r[CFG_RCM];
  wire [CNT_W-1:0] rcv_inc = rcv_r + CNT_W'(1);
  wire             rc_hit  = rcm & cur_ev & (rcv_inc == rcl_r);

  always_comb
  begin
    rcv_nxt = rcv_r;
    if (!rcm)
    begin
      rcv_nxt = '0;
    end
    else if (cur_ev)
    begin
      rcv_nxt = rc_hit ? '0 : rcv_inc;
    end
  end

  // ----------------------------------------------------------------
  // Result loading
  // ----------------------------------------------------------------
  // In counter mode a current result counts only at the limit
  wire cur_take = cur_ev & (~rcm | rc_hit);
  wire cur_ld   = cur_take & ~stat_r[ST_CUR_RDY];

  // Latest voltage and temperature in counter mode; newest wins
  wire [RES_W-1:0] v_new  = volt_res.valid ? volt_res.data : vsh_r;
  wire             v_have = volt_res.valid | vsh_v_r;
  wire [RES_W-1:0] t_new  = temp_res.valid ? temp_res.data : tsh_r;
  wire             t_have = temp_res.valid | tsh_v_r;

  wire v_src = rcm ? (rc_hit & v_have) : volt_res.valid;
  wire t_src = rcm ? (rc_hit & t_have) : temp_res.valid;
  wire v_ld  = v_src & ~stat_r[ST_VOLT_RDY];
  wire t_ld  = t_src & ~stat_r[ST_TEMP_RDY];

  // ----------------------------------------------------------------
  // Ready flag clearing by reads
  // ----------------------------------------------------------------
  wire cur_idle = ~mode_r[MODE_CUR_EN];
  wire clr_cur  = rd & hit_cur;
  wire clr_volt = rd & hit_volt & cur_idle;
  wire clr_temp = rd & hit_temp;

  wire [2:0] rdy_clr = clr_cur  ? 3'h7 :
                       clr_volt ? 3'h6 :
                       clr_temp ? 3'h4 : 3'h0;

  // ----------------------------------------------------------------
  // Overrange detector
  // ----------------------------------------------------------------
  // Low power mode is not checked here; software keeps it apart
  wire ovr_en   = cfg_r[CFG_OVR_EN];
  wire ovr_act  = ovr_en & ovr_raw;
  wire ovr_full = (ovc_r == OVR_W'(OVR_CYC));
  // Set on the cycle after OVR_CYC cycles, i.e. strictly longer
  wire ovr_set  = ovr_act & ovr_full;

  always_comb
  begin
    ovc_nxt = ovc_r;
    if (!ovr_act)
    begin
      ovc_nxt = '0;
    end
    else if (!ovr_full)
    begin
      ovc_nxt = ovc_r + OVR_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt flags
  // ----------------------------------------------------------------
  wire [ST_W-1:0] st_set;
  wire [ST_W-1:0] st_clr;
  wire [IRQ_W-1:0] ev_vec;
  wire [IRQ_W-1:0] ist_w1c;

  assign st_set[ST_CUR_RDY]  = cur_ld;
  assign st_set[ST_VOLT_RDY] = v_ld;
  assign st_set[ST_TEMP_RDY] = t_ld;
  assign st_set[ST_OVR]      = ovr_set;
  assign st_set[ST_CMP]      = cmp_ev;

  assign st_clr[ST_TEMP_RDY:ST_CUR_RDY] = rdy_clr;
  assign st_clr[ST_OVR]      = wr & hit_stat & pwdata[ST_OVR];
  assign st_clr[ST_CMP]      = wr & hit_stat & pwdata[ST_CMP];

  assign ev_vec[IRQ_CUR]  = cur_take;
  assign ev_vec[IRQ_CMP]  = cmp_ev;
  assign ev_vec[IRQ_OVR]  = ovr_set;
  assign ev_vec[IRQ_VOLT] = v_ld;
  assign ev_vec[IRQ_TEMP] = t_ld;

  assign ist_w1c = (wr & hit_ist) ? pwdata[IRQ_W-1:0] : IRQ_RST;

  // A set in the same cycle as a clear wins
  assign stat_nxt = (stat_r & ~st_clr) | st_set;
  assign ist_nxt  = (ist_r & ~ist_w1c) | ev_vec;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_r  <= CFG_RST;
      mode_r <= MODE_RST;
      thr_r  <= RES_RST;
      tcl_r  <= '0;
      rcl_r  <= '0;
      imsk_r <= IRQ_RST;
    end
    else if (wr)
    begin
      if (hit_cfg)  cfg_r  <= cfg_wdata;
      if (hit_mode) mode_r <= pwdata[7:0];
      if (hit_thr)  thr_r  <= pwdata[RES_W-1:0];
      if (hit_tcl)  tcl_r  <= pwdata[CNT_W-1:0];
      if (hit_rcl)  rcl_r  <= pwdata[CNT_W-1:0];
      if (hit_imsk) imsk_r <= pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Counters and flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      thv_r  <= '0;
      rcv_r  <= '0;
      ovc_r  <= '0;
      stat_r <= ST_RST;
      ist_r  <= IRQ_RST;
    end
    else
    begin
      thv_r  <= thv_nxt;
      rcv_r  <= rcv_nxt;
      ovc_r  <= ovc_nxt;
      stat_r <= stat_nxt;
      ist_r  <= ist_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur_r  <= RES_RST;
      volt_r <= RES_RST;
      temp_r <= RES_RST;
    end
    else
    begin
      if (cur_ld) cur_r  <= cur_res.data;
      if (v_ld)   volt_r <= v_new;
      if (t_ld)   temp_r <= t_new;
    end
  end

  // Shadows hold the latest result between counter limits
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      vsh_r   <= RES_RST;
      tsh_r   <= RES_RST;
      vsh_v_r <= 1'b0;
      tsh_v_r <= 1'b0;
    end
    else
    begin
      if (volt_res.valid) vsh_r <= volt_res.data;
      if (temp_res.valid) tsh_r <= temp_res.data;
      vsh_v_r <= rcm & ~rc_hit & v_have;
      tsh_v_r <= rcm & ~rc_hit & t_have;
    end
  end

  // ----------------------------------------------------------------
  // Bus response and outputs
  // ----------------------------------------------------------------
  // One wait state keeps prdata and pslverr registered
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      irq_r     <= 1'b0;
    end
    else
    begin
      pready_r  <= acc_first;
      pslverr_r <= acc_first & ~mapped;
      if (acc_first)
      begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      irq_r <= |(ist_r & imsk_r);
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign conv_mode = mode_r;
  assign irq       = irq_r;

endmodule

`default_nettype wire

// ---- arc_pkg.sv ----
// Purpose: Shared constants and types for the converter result logic
// Assumes: 50 MHz core clock, APB register access
// Notes:   Register byte addresses are full 32-bit APB addresses
package arc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int OVR_TIME_NS   = 125000;
  // Least time, so round up to whole cycles
  localparam int OVR_CYC_DEF   = (OVR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVR_W         = 16;
  localparam int CNT_W_DEF     = 8;
  localparam int RES_W         = 16;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CUR  = 32'hffff0520;
  localparam logic [31:0] ADDR_VOLT = 32'hffff0524;
  localparam logic [31:0] ADDR_TEMP = 32'hffff0528;
  localparam logic [31:0] ADDR_CFG  = 32'hffff0540;
  localparam logic [31:0] ADDR_STAT = 32'hffff0544;
  localparam logic [31:0] ADDR_THR  = 32'hffff0548;
  localparam logic [31:0] ADDR_TCL  = 32'hffff054c;
  localparam logic [31:0] ADDR_THV  = 32'hffff0550;
  localparam logic [31:0] ADDR_RCL  = 32'hffff0554;
  localparam logic [31:0] ADDR_RCV  = 32'hffff0558;
  localparam logic [31:0] ADDR_MODE = 32'hffff055c;
  localparam logic [31:0] ADDR_IMSK = 32'hffff0560;
  localparam logic [31:0] ADDR_IST  = 32'hffff0564;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_RCM     = 0;
  localparam int CFG_RSV     = 1;
  localparam int CFG_OVR_EN  = 2;
  localparam int CFG_CMP_LO  = 3;
  localparam int CFG_CMP_HI  = 4;
  localparam int MODE_CUR_EN = 0;
  localparam int ST_CUR_RDY  = 0;
  localparam int ST_VOLT_RDY = 1;
  localparam int ST_TEMP_RDY = 2;
  localparam int ST_OVR      = 3;
  localparam int ST_CMP      = 4;
  localparam int ST_W        = 5;
  localparam int IRQ_CUR     = 0;
  localparam int IRQ_CMP     = 1;
  localparam int IRQ_OVR     = 2;
  localparam int IRQ_VOLT    = 3;
  localparam int IRQ_TEMP    = 4;
  localparam int IRQ_W       = 5;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]       CFG_RST  = 8'h00;
  localparam logic [7:0]       MODE_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST  = 16'h0000;
  localparam logic [ST_W-1:0]  ST_RST   = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 5'h00;
  localparam logic [7:0]       CFG_WMSK = 8'hfd;

  typedef enum logic [1:0] {
    CMP_OFF     = 2'h0,
    CMP_EACH    = 2'h1,
    CMP_CNT_RST = 2'h2,
    CMP_CNT_DEC = 2'h3
  } arc_cmp_mode_t;

  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] data;
  } arc_res_t;

endpackage

// ---- arc_checker.sv ----
// Purpose: Bus, register and overrange assertions for arc_top
// Assumes: Bound into arc_top, one clock domain
// Notes:   Config, mask and overrange flag are mirrored from bus traffic and ovr_raw
`timescale 1ns/100ps
`default_nettype none
module arc_checker
  import arc_pkg::*;
#(
  parameter int OVR_CYC = OVR_CYC_DEF
)
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire arc_pkg::arc_res_t cur_res,
  input wire arc_pkg::arc_res_t volt_res,
  input wire arc_pkg::arc_res_t temp_res,
  input wire logic              ovr_raw,
  input wire logic [7:0]        conv_mode,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0]  cfg_r;
  logic [4:0]  msk_r;
  logic [15:0] run_r;
  logic        ovr_r;
  wire logic   wr      = psel && penable && pready && pwrite;
  wire logic   rd      = pready && !pwrite;
  wire logic   is_res  = paddr inside {ADDR_CUR, ADDR_VOLT, ADDR_TEMP};
  wire logic   is_map  = is_res || (paddr >= ADDR_CFG && paddr <= ADDR_IST && paddr[1:0] == 2'h0);
  wire logic   ovr_on  = ovr_raw && cfg_r[CFG_OVR_EN];
  // Run length saturates, so the flag keeps being set while still out of range
  wire logic   ovr_hit = ovr_on && (run_r >= 16'(OVR_CYC));
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_r <= 8'h00;
      msk_r <= 5'h00;
      run_r <= 16'h0000;
      ovr_r <= 1'b0;
    end
    else
    begin
      if (wr && paddr == ADDR_CFG)
        cfg_r <= pwdata[7:0];
      if (wr && paddr == ADDR_IMSK)
        msk_r <= pwdata[4:0];
      run_r <= !ovr_on ? 16'h0000 : (ovr_hit ? run_r : run_r + 16'h0001);
      if (ovr_hit)
        ovr_r <= 1'b1;
      else if (wr && paddr == ADDR_STAT && pwdata[ST_OVR])
        ovr_r <= 1'b0;
    end
  end
  AST_WAIT_ONE: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access phase length wrong");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (pready |-> pslverr == !is_map)
    else $error("error response does not match address map");
  AST_WR_ZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  AST_RES_NARROW: assert property (rd && is_res |-> prdata[31:16] == 16'h0000)
    else $error("result upper bits not zero");
  AST_CFG_RSV: assert property (rd && paddr == ADDR_CFG |-> prdata == {24'h0, cfg_r & CFG_WMSK})
    else $error("config readback wrong");
  AST_OVR_FLAG: assert property (rd && paddr == ADDR_STAT |-> prdata[ST_OVR] == ovr_r)
    else $error("overrange flag wrong");
  AST_MODE_COPY: assert property (wr && paddr == ADDR_MODE |=> conv_mode == $past(pwdata[7:0]))
    else $error("mode output does not follow write");
  AST_IRQ_MASKED: assert property (msk_r == 5'h00 |=> !irq)
    else $error("interrupt with all sources masked");
endmodule
bind arc_top arc_checker #(.OVR_CYC(OVR_CYC)) u_arc_chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cur_res(cur_res), .volt_res(volt_res), .temp_res(temp_res), .ovr_raw(ovr_raw),
  .conv_mode(conv_mode), .irq(irq)
);
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the converter result logic
// Assumes: Short overrange run length for simulation
// Notes:   Expected values come from the small model in the main sequence
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import arc_pkg::*;
  localparam int OVR = 20;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ovr_raw = 1'b0;
  logic        irq;
  logic [7:0]  conv_mode;
  arc_res_t    cur_res = '0;
  arc_res_t    volt_res = '0;
  arc_res_t    temp_res = '0;
  int          n_fail = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'hf6c92928;
  logic [31:0] rdv;
  logic        err;

  always #10 core_clk = ~core_clk;

  arc_top #(.OVR_CYC(OVR)) dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_res(cur_res), .volt_res(volt_res), .temp_res(temp_res), .ovr_raw(ovr_raw),
    .conv_mode(conv_mode), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pready and read data are taken at the edge itself, before that edge's updates land
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk(32'h0, 32'h1);
      test_done();
    end
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conv(input int ch, input logic [15:0] d);
    @(posedge core_clk);
    if (ch == 0)
      cur_res <= '{1'b1, d};
    else if (ch == 1)
      volt_res <= '{1'b1, d};
    else
      temp_res <= '{1'b1, d};
    @(posedge core_clk);
    cur_res.valid  <= 1'b0;
    volt_res.valid <= 1'b0;
    temp_res.valid <= 1'b0;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] c1;
    logic [15:0] v1;
    logic [15:0] t1;
    logic [15:0] d;
    logic        ev;
    int          cnt;
    int          dv;
    logic [15:0] vq[$];
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++)
      rdc((i < 3) ? ADDR_CUR + 4 * i : ADDR_CFG + 4 * (i - 3), 32'h0);
    rdc(ADDR_CUR + 32'hc, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, ADDR_CUR, 32'hffff);
    rdc(ADDR_CUR, 32'h0);
    apb(1'b1, ADDR_CFG, 32'hfd);
    rdc(ADDR_CFG, 32'hfd);
    apb(1'b1, ADDR_CFG, 32'h0);
    apb(1'b1, ADDR_IMSK, 32'h1f);
    c1 = rnd();
    v1 = rnd();
    t1 = rnd();
    conv(1, v1);
    conv(2, t1);
    conv(0, c1);
    conv(0, ~c1);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b1);
    rdc(ADDR_STAT, 32'h7);
    rdc(ADDR_CUR, c1);
    rdc(ADDR_STAT, 32'h0);
    rdc(ADDR_IST, 32'h19);
    apb(1'b1, ADDR_IMSK, 32'h0);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IST, 32'h1f);
    rdc(ADDR_IST, 32'h0);
    apb(1'b1, ADDR_IMSK, 32'h1f);
    apb(1'b1, ADDR_MODE, 32'h1);
    conv(1, ~v1);
    chk(conv_mode, 32'h1);
    conv(1, v1);
    conv(2, ~t1);
    rdc(ADDR_VOLT, {16'h0, ~v1});
    rdc(ADDR_STAT, 32'h6);
    apb(1'b1, ADDR_MODE, 32'h0);
    rdc(ADDR_VOLT, {16'h0, ~v1});
    rdc(ADDR_STAT, 32'h0);
    conv(2, t1);
    conv(2, ~t1);
    conv(0, c1);
    rdc(ADDR_TEMP, t1);
    rdc(ADDR_STAT, 32'h1);
    rdc(ADDR_CUR, c1);
    apb(1'b1, ADDR_THR, 32'h4000);
    apb(1'b1, ADDR_TCL, 32'h3);
    // The counter is not cleared when one counting mode follows the other
    cnt = 0;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, ADDR_CFG, m << 3);
      for (int k = 0; k < 14; k++)
      begin
        d = (k == 0) ? 16'h4000 : (k == 1) ? 16'hc000 : (k == 2) ? 16'h3fff :
            (k == 3) ? 16'h8000 : rnd();
        dv = $signed(d);
        dv = (dv < 0) ? -dv : dv;
        ev = (m == 1) && (dv >= 16384);
        if (m > 1 && dv >= 16384)
        begin
          ev = (cnt + 1 >= 3);
          cnt = ev ? 0 : cnt + 1;
        end
        else if (m == 2)
          cnt = 0;
        else if (m == 3 && cnt > 0)
          cnt--;
        conv(0, d);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rdv[ST_CMP], ev);
        rdc(ADDR_THV, cnt);
        rdc(ADDR_CUR, d);
        apb(1'b1, ADDR_STAT, 32'h10);
      end
    end
    apb(1'b1, ADDR_IST, 32'h1f);
    apb(1'b1, ADDR_RCL, 32'h3);
    apb(1'b1, ADDR_CFG, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      vq.push_back(rnd());
      d = rnd();
      conv(1, vq[$]);
      conv(0, d);
      apb(1'b0, ADDR_IST, 32'h0);
      chk(rdv[IRQ_CUR], i % 3 == 2);
      rdc(ADDR_RCV, (i + 1) % 3);
      if (i % 3 == 2)
      begin
        rdc(ADDR_VOLT, vq[$]);
        rdc(ADDR_CUR, d);
        apb(1'b1, ADDR_IST, 32'h1f);
      end
    end
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, ADDR_CFG, (k > 0) ? 32'h4 : 32'h0);
      ovr_raw <= 1'b1;
      repeat ((k == 1) ? OVR - 2 : OVR + 10) @(posedge core_clk);
      ovr_raw <= 1'b0;
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rdv[ST_OVR], k == 2);
      apb(1'b0, ADDR_IST, 32'h0);
      chk(rdv[IRQ_OVR], k == 2);
      apb(1'b1, ADDR_STAT, 32'h8);
      apb(1'b1, ADDR_IST, 32'h1f);
    end
    test_done();
  end
endmodule
`default_nettype wire
